// File: verilog/pkw_pkg.sv
// Constants for the power-key and charger-wake block
package pkw_pkg;
    // Clock rate and derived times
    localparam int unsigned CLK_HZ      = 50000000;
    localparam int unsigned MS_PER_S    = 1000;
    localparam int unsigned KEY_TIME_S  = 2;
    localparam int unsigned DEBOUNCE_MS = 10;
    localparam int unsigned MS_CYC      = CLK_HZ / MS_PER_S;
    localparam int unsigned DB_CYC      = DEBOUNCE_MS * MS_CYC;
    localparam logic [15:0] KEY_MS_RST  =
        16'(KEY_TIME_S * MS_PER_S);

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_EVENT  = 8'h08;
    localparam logic [7:0] OFS_KTIME  = 8'h0C;
    localparam logic [7:0] OFS_POWER  = 8'h10;

    // Control field positions
    localparam int unsigned CTL_MODE_LO = 0;
    localparam int unsigned CTL_MODE_HI = 1;
    localparam int unsigned CTL_KMASK   = 2;
    localparam int unsigned CTL_WMASK   = 3;
    localparam int unsigned CTL_ODRAIN  = 4;

    // Status, event and power field positions
    localparam int unsigned ST_KEY   = 0;
    localparam int unsigned ST_LOCK  = 1;
    localparam int unsigned EV_KEY   = 0;
    localparam int unsigned EV_WAKE  = 1;
    localparam int unsigned EV_LOCK  = 2;
    localparam int unsigned PW_SYS   = 0;
    localparam int unsigned PW_STBY  = 1;

    // Reset values
    localparam logic [4:0] CTRL_RST  = 5'h00;
    localparam logic [1:0] POWER_RST = 2'h1;

    // Key modes
    localparam logic [1:0] MODE_EDGE  = 2'h0;
    localparam logic [1:0] MODE_LOCK  = 2'h1;
    localparam logic [1:0] MODE_OFF   = 2'h2;
    localparam logic [1:0] MODE_STBY  = 2'h3;

    // AHB transfer type bit for active transfers
    localparam int unsigned HTRANS_ACT = 1;

    // Key tracker states
    typedef enum logic [2:0] {
        KS_IDLE  = 3'b001,
        KS_PRESS = 3'b010,
        KS_HELD  = 3'b100
    } pkw_key_state_t;
endpackage

// File: verilog/pkw_top.sv
// Power-key and charger-wake logic with AHB-Lite registers
`timescale 1ns/1ps
module pkw_top #(
    parameter int unsigned MS_CYC = pkw_pkg::MS_CYC,
    parameter int unsigned DB_CYC = pkw_pkg::DB_CYC
) (
    // Clock, reset, enable
    input  wire logic        SYS_CLK,
    input  wire logic        RST,
    input  wire logic        CLK_EN,
    // AHB-Lite slave
    input  wire logic        HSEL,
    input  wire logic [7:0]  HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic             HREADYOUT,
    output logic [31:0]      HRDATA,
    output logic             HRESP,
    // Pins from outside
    input  wire logic        POWER_KEY_N,
    input  wire logic        CHARGER_WAKE_IN,
    // Sequencer status, same clock
    input  wire logic        CFG_LOADED,
    input  wire logic        LOW_POWER_STATE,
    input  wire logic        RTC_MODE,
    input  wire logic        HOST_RESET_REQ,
    // Sequencer controls
    output logic             SYSTEM_EN,
    output logic             STANDBY,
    output logic             WAKE_EVT,
    output logic             STARTUP_REQ,
    // Pins to outside
    output logic             IRQ_OUT_O,
    output logic             IRQ_OUT_OE,
    output logic             HOST_RESET_O,
    output logic             HOST_RESET_OE,
    output logic             KEY_LOCK_O,
    output logic             KEY_LOCK_OE
);
    // Registers
    logic [4:0]  ctrl_reg;
    logic [15:0] ktime_reg;
    logic [1:0]  power_reg;
    logic        key_ev_reg;
    logic        wake_ev_reg;
    logic        lock_reg;
    logic        off_by_key_reg;
    logic [1:0]  key_sync_reg;
    logic [1:0]  chg_sync_reg;
    logic        chg_prev_reg;
    logic        key_db_reg;
    logic [31:0] db_cnt_reg;
    logic [31:0] pre_cnt_reg;
    logic [15:0] press_ms_reg;
    logic        lp_prev_reg;
    logic        a_wr_reg;
    logic [7:0]  a_addr_reg;
    logic [31:0] rdata_reg;
    logic        wake_reg;
    logic        start_reg;
    logic        irq_o_reg;
    logic        irq_oe_reg;
    logic        rst_o_reg;
    logic        rst_oe_reg;
    logic        lk_o_reg;
    logic        lk_oe_reg;
    pkw_pkg::pkw_key_state_t ks_reg;
    pkw_pkg::pkw_key_state_t ks_next;

    // Field views
    wire [1:0] mode    = ctrl_reg[pkw_pkg::CTL_MODE_HI:
                                  pkw_pkg::CTL_MODE_LO];
    wire       kmask   = ctrl_reg[pkw_pkg::CTL_KMASK];
    wire       wmask   = ctrl_reg[pkw_pkg::CTL_WMASK];
    wire       odrain  = ctrl_reg[pkw_pkg::CTL_ODRAIN];
    wire       edge_md = mode == pkw_pkg::MODE_EDGE;

    // Bus decode
    wire addr_ok  = HSEL && HTRANS[pkw_pkg::HTRANS_ACT] && HREADY;
    wire wr_ctrl  = a_wr_reg && a_addr_reg == pkw_pkg::OFS_CTRL;
    wire wr_event = a_wr_reg && a_addr_reg == pkw_pkg::OFS_EVENT;
    wire wr_ktime = a_wr_reg && a_addr_reg == pkw_pkg::OFS_KTIME;
    wire wr_power = a_wr_reg && a_addr_reg == pkw_pkg::OFS_POWER;

    // Key edges and timing, debounced level only
    wire key_on   = key_db_reg;
    wire tick     = pre_cnt_reg == 32'(MS_CYC - 1);
    wire press    = ks_reg == pkw_pkg::KS_IDLE && key_on;
    wire release_ = ks_reg != pkw_pkg::KS_IDLE && !key_on;
    wire long_hit = ks_reg == pkw_pkg::KS_PRESS && key_on &&
                    press_ms_reg >= ktime_reg;
    wire short_rl = ks_reg == pkw_pkg::KS_PRESS && !key_on;
    wire rtc      = RTC_MODE;
    wire lp       = LOW_POWER_STATE;

    // Charger edge from synchronised level
    wire chg_rise = chg_sync_reg[1] && !chg_prev_reg;

    // Key event causes per mode
    wire ev_edge  = !rtc && edge_md && press;
    wire ev_short = !rtc && !edge_md && short_rl &&
                    !(lock_reg && lp);
    wire ev_long  = !rtc && !edge_md && long_hit;
    wire key_set  = ev_edge || ev_short || ev_long;

    // Wake causes
    wire wk_key   = lp && ((ev_edge && !kmask) ||
                           ev_short || ev_long);
    wire wk_chg   = !rtc && lp && chg_rise && !wmask;
    wire start_go = rtc && (press || chg_rise);

    // Power enable decisions
    wire lock_set = ev_long;
    wire sys_clr  = (ev_long && mode != pkw_pkg::MODE_LOCK) ||
                    (ev_short && mode == pkw_pkg::MODE_STBY);
    wire stby_set = ev_short && mode == pkw_pkg::MODE_STBY;
    wire stby_clr = ev_long && mode == pkw_pkg::MODE_STBY;
    wire sys_back = press && off_by_key_reg && !rtc;
    wire powerup  = lp_prev_reg && !lp;

    // Interrupt level, key and charger each gated by its mask
    wire irq_lvl  = (key_ev_reg && !kmask) ||
                    (wake_ev_reg && !wmask);

    // Read mux
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (HADDR)
            pkw_pkg::OFS_CTRL:   rd_mux = 32'(ctrl_reg);
            pkw_pkg::OFS_STATUS: rd_mux = 32'({lock_reg, key_db_reg});
            pkw_pkg::OFS_EVENT:  rd_mux = 32'({lock_reg, wake_ev_reg,
                                               key_ev_reg});
            pkw_pkg::OFS_KTIME:  rd_mux = 32'(ktime_reg);
            pkw_pkg::OFS_POWER:  rd_mux = 32'(power_reg);
            default:             rd_mux = 32'h0000_0000;
        endcase
    end

    // Key tracker next state
    always_comb begin
        ks_next = ks_reg;
        unique case (ks_reg)
            pkw_pkg::KS_IDLE: begin
                if (key_on) begin
                    ks_next = pkw_pkg::KS_PRESS;
                end
            end
            pkw_pkg::KS_PRESS: begin
                if (!key_on) begin
                    ks_next = pkw_pkg::KS_IDLE;
                end else if (long_hit) begin
                    ks_next = pkw_pkg::KS_HELD;
                end
            end
            pkw_pkg::KS_HELD: begin
                if (release_) begin
                    ks_next = pkw_pkg::KS_IDLE;
                end
            end
            default: ks_next = pkw_pkg::KS_IDLE;
        endcase
    end

    // Pin synchronisers
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            key_sync_reg <= 2'h0;
            chg_sync_reg <= 2'h0;
            chg_prev_reg <= 1'b0;
        end else if (CLK_EN) begin
            key_sync_reg <= {key_sync_reg[0], !POWER_KEY_N};
            chg_sync_reg <= {chg_sync_reg[0], CHARGER_WAKE_IN};
            chg_prev_reg <= chg_sync_reg[1];
        end
    end

    // Debounce filter, level held for DB_CYC cycles
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            key_db_reg <= 1'b0;
            db_cnt_reg <= 32'h0000_0000;
        end else if (CLK_EN) begin
            if (key_sync_reg[1] == key_db_reg) begin
                db_cnt_reg <= 32'h0000_0000;
            end else if (db_cnt_reg == 32'(DB_CYC - 1)) begin
                key_db_reg <= key_sync_reg[1];
                db_cnt_reg <= 32'h0000_0000;
            end else begin
                db_cnt_reg <= db_cnt_reg + 32'h0000_0001;
            end
        end
    end

    // Millisecond prescaler and press length
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            pre_cnt_reg  <= 32'h0000_0000;
            press_ms_reg <= 16'h0000;
            ks_reg       <= pkw_pkg::KS_IDLE;
        end else if (CLK_EN) begin
            ks_reg <= ks_next;
            if (press || tick) begin
                pre_cnt_reg <= 32'h0000_0000;
            end else begin
                pre_cnt_reg <= pre_cnt_reg + 32'h0000_0001;
            end
            if (press) begin
                press_ms_reg <= 16'h0000;
            end else if (tick && press_ms_reg != 16'hFFFF) begin
                press_ms_reg <= press_ms_reg + 16'h0001;
            end
        end
    end

    // Bus address phase capture and read data
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            a_wr_reg   <= 1'b0;
            a_addr_reg <= 8'h00;
            rdata_reg  <= 32'h0000_0000;
        end else if (CLK_EN) begin
            a_wr_reg <= addr_ok && HWRITE;
            if (addr_ok) begin
                a_addr_reg <= HADDR;
                rdata_reg  <= HWRITE ? 32'h0000_0000 : rd_mux;
            end
        end
    end

    // Software configuration
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            ctrl_reg  <= pkw_pkg::CTRL_RST;
            ktime_reg <= pkw_pkg::KEY_MS_RST;
        end else if (CLK_EN) begin
            if (wr_ctrl) begin
                ctrl_reg <= HWDATA[4:0];
            end
            if (wr_ktime) begin
                ktime_reg <= HWDATA[15:0];
            end
        end
    end

    // Event flags, hardware set beats software clear
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            key_ev_reg  <= 1'b0;
            wake_ev_reg <= 1'b0;
            lock_reg    <= 1'b0;
        end else if (CLK_EN) begin
            if (key_set) begin
                key_ev_reg <= 1'b1;
            end else if (wr_event && HWDATA[pkw_pkg::EV_KEY]) begin
                key_ev_reg <= 1'b0;
            end
            if (!rtc && chg_rise) begin
                wake_ev_reg <= 1'b1;
            end else if (wr_event && HWDATA[pkw_pkg::EV_WAKE]) begin
                wake_ev_reg <= 1'b0;
            end
            if (lock_set) begin
                lock_reg <= 1'b1;
            end else if (powerup) begin
                lock_reg <= 1'b0;
            end else if (wr_event && HWDATA[pkw_pkg::EV_LOCK]) begin
                lock_reg <= 1'b0;
            end
        end
    end

    // Domain enables, key actions beat software writes
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            power_reg      <= pkw_pkg::POWER_RST;
            off_by_key_reg <= 1'b0;
            lp_prev_reg    <= 1'b0;
        end else if (CLK_EN) begin
            lp_prev_reg <= lp;
            if (sys_clr) begin
                power_reg[pkw_pkg::PW_SYS] <= 1'b0;
                off_by_key_reg             <= 1'b1;
            end else if (sys_back) begin
                power_reg[pkw_pkg::PW_SYS] <= 1'b1;
                off_by_key_reg             <= 1'b0;
            end else if (wr_power) begin
                power_reg[pkw_pkg::PW_SYS] <= HWDATA[pkw_pkg::PW_SYS];
                off_by_key_reg             <= 1'b0;
            end
            if (stby_set) begin
                power_reg[pkw_pkg::PW_STBY] <= 1'b1;
            end else if (stby_clr) begin
                power_reg[pkw_pkg::PW_STBY] <= 1'b0;
            end else if (wr_power) begin
                power_reg[pkw_pkg::PW_STBY] <=
                    HWDATA[pkw_pkg::PW_STBY];
            end
        end
    end

    // Sequencer pulses
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            wake_reg  <= 1'b0;
            start_reg <= 1'b0;
        end else if (CLK_EN) begin
            wake_reg  <= wk_key || wk_chg;
            start_reg <= start_go;
        end
    end

    // Pin drivers, active-low irq and reset
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            irq_o_reg  <= 1'b1;
            irq_oe_reg <= 1'b1;
            rst_o_reg  <= 1'b0;
            rst_oe_reg <= 1'b1;
            lk_o_reg   <= 1'b0;
            lk_oe_reg  <= 1'b0;
        end else if (CLK_EN) begin
            irq_o_reg  <= odrain ? 1'b0 : !irq_lvl;
            irq_oe_reg <= odrain ? irq_lvl : 1'b1;
            rst_o_reg  <= odrain ? 1'b0 : !HOST_RESET_REQ;
            rst_oe_reg <= odrain ? HOST_RESET_REQ : 1'b1;
            lk_o_reg   <= lock_reg;
            lk_oe_reg  <= CFG_LOADED;
        end
    end

    // Output wiring
    assign HREADYOUT     = 1'b1;
    assign HRESP         = 1'b0;
    assign HRDATA        = rdata_reg;
    assign SYSTEM_EN     = power_reg[pkw_pkg::PW_SYS];
    assign STANDBY       = power_reg[pkw_pkg::PW_STBY];
    assign WAKE_EVT      = wake_reg;
    assign STARTUP_REQ   = start_reg;
    assign IRQ_OUT_O     = irq_o_reg;
    assign IRQ_OUT_OE    = irq_oe_reg;
    assign HOST_RESET_O  = rst_o_reg;
    assign HOST_RESET_OE = rst_oe_reg;
    assign KEY_LOCK_O    = lk_o_reg;
    assign KEY_LOCK_OE   = lk_oe_reg;

    // HSIZE is accepted but all accesses act as whole words
    wire unused_ok = &{1'b0, HSIZE};
endmodule

// File: bench/pkw_monitor.sv
// Property checker for the power-key and charger-wake block
`timescale 1ns/1ps
module pkw_monitor #(
    parameter int unsigned MS_CYC = pkw_pkg::MS_CYC,
    parameter int unsigned DB_CYC = pkw_pkg::DB_CYC
) (
    // Clock, reset, enable
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic CLK_EN,
    // Sequencer status and pins in
    input wire logic CFG_LOADED,
    input wire logic LOW_POWER_STATE,
    input wire logic RTC_MODE,
    input wire logic HOST_RESET_REQ,
    input wire logic CHARGER_WAKE_IN,
    // Outputs watched
    input wire logic WAKE_EVT,
    input wire logic STARTUP_REQ,
    input wire logic SYSTEM_EN,
    input wire logic IRQ_OUT_O,
    input wire logic IRQ_OUT_OE,
    input wire logic HOST_RESET_O,
    input wire logic HOST_RESET_OE,
    input wire logic KEY_LOCK_O,
    input wire logic KEY_LOCK_OE
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    logic seen_cfg;

    // Remembers that configuration has arrived
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) seen_cfg <= 1'b0;
        else if (CLK_EN && CFG_LOADED) seen_cfg <= 1'b1;
    end

    a_lock_pin_float: assert property (
        !seen_cfg |-> !KEY_LOCK_OE) else $error("lock pin driven early");
    a_irq_drive_kind: assert property (
        !(IRQ_OUT_O && !IRQ_OUT_OE)) else $error("irq pin floats high");
    a_reset_pin_low: assert property (
        HOST_RESET_REQ && CLK_EN |=> HOST_RESET_OE && !HOST_RESET_O)
        else $error("host reset not driven low");
    a_reset_pin_free: assert property (
        !HOST_RESET_REQ && CLK_EN |=> HOST_RESET_O || !HOST_RESET_OE)
        else $error("host reset held low");
    a_wake_one_cycle: assert property (
        WAKE_EVT |=> !WAKE_EVT) else $error("wake pulse too long");
    a_wake_low_power: assert property (
        WAKE_EVT |-> $past(LOW_POWER_STATE))
        else $error("wake outside low power");
    a_rtc_no_wake: assert property (
        RTC_MODE && $past(RTC_MODE, 2) |-> !WAKE_EVT)
        else $error("wake during rtc mode");
    a_startup_cause: assert property (
        STARTUP_REQ |-> $past(RTC_MODE) ##1 !STARTUP_REQ)
        else $error("startup pulse without rtc mode");
    a_chg_ends_rtc: assert property (
        $rose(CHARGER_WAKE_IN) && RTC_MODE |-> ##[1:8] STARTUP_REQ)
        else $error("charger rise did not end rtc mode");
    a_lock_powerup: assert property (
        $fell(LOW_POWER_STATE) |-> ##[1:4] !KEY_LOCK_O)
        else $error("lock kept after power up");

    // Main scenarios reached
    c_wake: cover property (WAKE_EVT);
    c_start: cover property (STARTUP_REQ);
    c_sys_off: cover property ($fell(SYSTEM_EN));
endmodule

bind pkw_top pkw_monitor #(.MS_CYC(MS_CYC), .DB_CYC(DB_CYC)) mon_u (
    .SYS_CLK(SYS_CLK), .RST(RST), .CLK_EN(CLK_EN),
    .CFG_LOADED(CFG_LOADED), .LOW_POWER_STATE(LOW_POWER_STATE),
    .RTC_MODE(RTC_MODE), .HOST_RESET_REQ(HOST_RESET_REQ),
    .CHARGER_WAKE_IN(CHARGER_WAKE_IN), .WAKE_EVT(WAKE_EVT),
    .STARTUP_REQ(STARTUP_REQ), .SYSTEM_EN(SYSTEM_EN),
    .IRQ_OUT_O(IRQ_OUT_O), .IRQ_OUT_OE(IRQ_OUT_OE),
    .HOST_RESET_O(HOST_RESET_O), .HOST_RESET_OE(HOST_RESET_OE),
    .KEY_LOCK_O(KEY_LOCK_O), .KEY_LOCK_OE(KEY_LOCK_OE));

// File: bench/pkw_key_model.sv
// Push button with pull-up and charger wake line
`timescale 1ns/1ps
module pkw_key_model (
    // Pins toward the block
    output logic key_n,
    output logic charger_wake_in
);
    // Released button rests at the pull-up level
    initial begin
        key_n = 1'b1;
        charger_wake_in = 1'b0;
    end

    // Press or release, called just after a clock edge
    task automatic set_key(input logic down);
        key_n <= ~down;
    endtask

    // Charger side raises or drops its wake line
    task automatic set_chg(input logic hi);
        charger_wake_in <= hi;
    endtask
endmodule

// File: bench/tb_top.sv
// Self-checking bench for the power-key and charger-wake block
`timescale 1ns/1ps
module tb_top;
    logic        SYS_CLK = 1'b0;
    logic        RST = 1'b1;
    logic        HSEL = 1'b0;
    logic        HWRITE = 1'b0;
    logic [7:0]  HADDR = 8'h00;
    logic [1:0]  HTRANS = 2'h0;
    logic [31:0] HWDATA = 32'h0;
    logic        CFG_LOADED = 1'b0;
    logic        LOW_POWER_STATE = 1'b0;
    logic        RTC_MODE = 1'b0;
    logic        HOST_RESET_REQ = 1'b0;
    logic        HREADYOUT, HRESP, SYSTEM_EN, STANDBY, WAKE_EVT;
    logic        STARTUP_REQ, IRQ_OUT_O, IRQ_OUT_OE, HOST_RESET_O;
    logic        HOST_RESET_OE, KEY_LOCK_O, KEY_LOCK_OE, key_n, chg;
    logic [31:0] HRDATA;
    int          mismatches = 0, cmp_count = 0, wakes = 0, starts = 0;

    pkw_top #(.MS_CYC(10), .DB_CYC(4)) dut_u (
        .SYS_CLK(SYS_CLK), .RST(RST), .CLK_EN(1'b1), .HSEL(HSEL),
        .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
        .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
        .HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(HRESP),
        .POWER_KEY_N(key_n), .CHARGER_WAKE_IN(chg),
        .CFG_LOADED(CFG_LOADED), .LOW_POWER_STATE(LOW_POWER_STATE),
        .RTC_MODE(RTC_MODE), .HOST_RESET_REQ(HOST_RESET_REQ),
        .SYSTEM_EN(SYSTEM_EN), .STANDBY(STANDBY), .WAKE_EVT(WAKE_EVT),
        .STARTUP_REQ(STARTUP_REQ), .IRQ_OUT_O(IRQ_OUT_O),
        .IRQ_OUT_OE(IRQ_OUT_OE), .HOST_RESET_O(HOST_RESET_O),
        .HOST_RESET_OE(HOST_RESET_OE), .KEY_LOCK_O(KEY_LOCK_O),
        .KEY_LOCK_OE(KEY_LOCK_OE));
    pkw_key_model key_u (.key_n(key_n), .charger_wake_in(chg));

    // 50 MHz clock
    always #10 SYS_CLK = ~SYS_CLK;

    // Count sequencer pulses
    always @(posedge SYS_CLK) begin
        wakes <= wakes + int'(WAKE_EVT === 1'b1);
        starts <= starts + int'(STARTUP_REQ === 1'b1);
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge SYS_CLK);
    endtask

    task automatic check(input string nm, input logic [31:0] exp,
                         input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", nm, exp, got);
            mismatches++;
        end
    endtask

    // One single AHB-Lite transfer, address then data phase
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge SYS_CLK);
        HSEL <= 1'b1;
        HADDR <= a;
        HWRITE <= wr;
        HTRANS <= 2'h2;
        do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= wd;
        do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
        rd = HRDATA;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a,
                          input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        check(nm, exp, x);
    endtask

    // Button and charger moves, then time to settle
    task automatic key(input logic d);
        @(posedge SYS_CLK);
        key_u.set_key(d);
        cyc(12);
    endtask

    task automatic chg_set(input logic d);
        @(posedge SYS_CLK);
        key_u.set_chg(d);
        cyc(8);
    endtask

    task automatic t_reset();
        rd_chk("ctrl", 8'h00, 32'h0);
        rd_chk("event", 8'h08, 32'h0);
        rd_chk("ktime", 8'h0C, 32'(pkw_pkg::KEY_MS_RST));
        rd_chk("power", 8'h10, 32'h1);
        rd_chk("unmapped", 8'h14, 32'h0);
        wr(8'h04, 32'hFF);
        rd_chk("status ro", 8'h04, 32'h0);
        check("lock oe early", 32'h0, 32'(KEY_LOCK_OE));
        CFG_LOADED <= 1'b1;
        cyc(3);
        check("lock oe", 32'h1, 32'(KEY_LOCK_OE));
        wr(8'h00, 32'h10);
        cyc(2);
        check("rst od idle", 32'h0, 32'(HOST_RESET_OE));
        check("irq od idle", 32'h0, 32'(IRQ_OUT_OE));
        check("hresp", 32'h0, 32'(HRESP));
        HOST_RESET_REQ <= 1'b1;
        cyc(3);
        check("rst od on", 32'h2, 32'({HOST_RESET_OE, HOST_RESET_O}));
        HOST_RESET_REQ <= 1'b0;
        wr(8'h00, 32'h0);
        wr(8'h0C, 32'h3);
    endtask

    task automatic t_edge();
        int w0;
        LOW_POWER_STATE <= 1'b1;
        w0 = wakes;
        @(posedge SYS_CLK);
        key_u.set_key(1'b1);
        cyc(2);
        key(1'b0);
        rd_chk("glitch", 8'h08, 32'h0);
        key(1'b1);
        check("irq pin", 32'h0, 32'(IRQ_OUT_O));
        rd_chk("status key", 8'h04, 32'h1);
        check("edge wake", 32'(w0 + 1), 32'(wakes));
        key(1'b0);
        wr(8'h00, 32'h4);
        wr(8'h08, 32'h7);
        key(1'b1);
        check("masked irq", 32'h1, 32'(IRQ_OUT_O));
        key(1'b0);
        check("masked wake", 32'(w0 + 1), 32'(wakes));
        LOW_POWER_STATE <= 1'b0;
    endtask

    task automatic t_modes();
        logic [1:0] pw_s [1:3] = '{2'b01, 2'b01, 2'b10};
        logic [1:0] pw_l [1:3] = '{2'b01, 2'b00, 2'b00};
        for (int m = 1; m < 4; m++) begin
            wr(8'h00, 32'(m));
            wr(8'h10, 32'h1);
            wr(8'h08, 32'h7);
            key(1'b1);
            rd_chk("ev held", 8'h08, 32'h0);
            key(1'b0);
            rd_chk("ev short", 8'h08, 32'h1);
            check("pw short", 32'(pw_s[m]), 32'({STANDBY, SYSTEM_EN}));
            wr(8'h10, 32'h1);
            wr(8'h08, 32'h7);
            key(1'b1);
            cyc(40);
            rd_chk("ev long", 8'h08, 32'h5);
            check("pw long", 32'(pw_l[m]), 32'({STANDBY, SYSTEM_EN}));
            check("lock pin", 32'h1, 32'(KEY_LOCK_O));
            key(1'b0);
            if (m == 2) begin
                key(1'b1);
                key(1'b0);
                check("sys again", 32'h1, 32'(SYSTEM_EN));
            end
        end
    endtask

    task automatic t_lock();
        int w0;
        wr(8'h00, 32'h5);
        key(1'b1);
        cyc(40);
        key(1'b0);
        LOW_POWER_STATE <= 1'b1;
        w0 = wakes;
        key(1'b1);
        key(1'b0);
        check("locked short", 32'(w0), 32'(wakes));
        key(1'b1);
        cyc(40);
        key(1'b0);
        check("locked long", 32'(w0 + 1), 32'(wakes));
        LOW_POWER_STATE <= 1'b0;
        cyc(4);
        rd_chk("lock cleared", 8'h04, 32'h0);
        key(1'b1);
        cyc(40);
        key(1'b0);
        wr(8'h08, 32'h4);
        LOW_POWER_STATE <= 1'b1;
        key(1'b1);
        key(1'b0);
        check("unlocked short", 32'(w0 + 2), 32'(wakes));
    endtask

    task automatic t_charger();
        int w0;
        int s0;
        wr(8'h00, 32'h0);
        wr(8'h08, 32'h7);
        w0 = wakes;
        chg_set(1'b1);
        check("charger_wake_in", 32'(w0 + 1), 32'(wakes));
        check("chg irq", 32'h0, 32'(IRQ_OUT_O));
        chg_set(1'b0);
        rd_chk("chg event", 8'h08, 32'h2);
        wr(8'h00, 32'h8);
        wr(8'h08, 32'h7);
        chg_set(1'b1);
        chg_set(1'b0);
        check("chg masked", 32'(w0 + 1), 32'(wakes));
        check("chg irq off", 32'h1, 32'(IRQ_OUT_O));
        wr(8'h08, 32'h7);
        RTC_MODE <= 1'b1;
        s0 = starts;
        chg_set(1'b1);
        chg_set(1'b0);
        check("rtc chg", 32'(s0 + 1), 32'(starts));
        key(1'b1);
        key(1'b0);
        check("rtc key", 32'(s0 + 2), 32'(starts));
        rd_chk("rtc event", 8'h08, 32'h0);
        RTC_MODE <= 1'b0;
        LOW_POWER_STATE <= 1'b0;
    endtask

    task automatic conclude();
        $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        cyc(20);
        RST <= 1'b0;
        t_reset();
        t_edge();
        t_modes();
        t_lock();
        t_charger();
        conclude();
    end

    // Watchdog well beyond the expected run of under a thousand cycles
    initial begin
        cyc(20000);
        mismatches++;
        conclude();
    end
endmodule
